// >>> hdl/pin_mux_defines.svh
// Constants for the port B / port C pin-function multiplexer
`ifndef PIN_MUX_DEFINES_SVH
`define PIN_MUX_DEFINES_SVH

// ************************************************************
// Pad positions in the pad vectors
// ************************************************************
`define PIN_COUNT 8
`define PIN_B1 0
`define PIN_B2 1
`define PIN_B3 2
`define PIN_C6 3
`define PIN_C7 4
`define PIN_C8 5
`define PIN_C9 6
`define PIN_C10 7

// ************************************************************
// Field widths and vector positions
// ************************************************************
`define FUNC_WIDTH 4
`define CMP_COUNT 4
`define DAC_WIDTH 12
`define XBAR_OUT_COUNT 3
`define XBAR_OUT_6 0
`define XBAR_OUT_8 1
`define XBAR_OUT_9 2
`define XBAR_IN_COUNT 5
`define XBAR_IN_3 0
`define XBAR_IN_4 1
`define XBAR_IN_5 2
`define XBAR_IN_8 3
`define XBAR_IN_9 4

// ************************************************************
// Reset values
// ************************************************************
`define GPIO_DIR_RESET 8'h00
`define GPIO_OUT_RESET 8'h00
`define DAC_RESET 12'h000

`endif

// >>> hdl/pin_mux_pkg.sv
// Types shared by the pin-function multiplexer and its users
`include "pin_mux_defines.svh"

package pin_mux_pkg;

   // ************************************************************
   // Pad function codes
   // ************************************************************
   typedef enum logic [`FUNC_WIDTH-1:0] {
      func_gpio,
      func_analog,
      func_dac,
      func_timer,
      func_xbar_in,
      func_comparator_shared_reference,
      func_ss,
      func_txd,
      func_miso,
      func_rxd,
      func_xbar_out,
      func_sclk,
      func_mosi
   } pin_func_type;

   typedef struct packed {
      pin_func_type [`PIN_COUNT-1:0] func;
      logic [`PIN_COUNT-1:0] gpio_dir;
      logic [`PIN_COUNT-1:0] gpio_out;
      logic pin_2_ref_high;
      logic pin_3_ref_low;
   } pin_cfg_type;

   // ************************************************************
   // Analog switch controls
   // ************************************************************
   typedef struct packed {
      logic adc2_channel_1;
      logic comparator2_input0;
      logic dac2_output;
      logic adc2_channel_2;
      logic adc2_ref_high;
      logic comparator3_input3;
      logic adc2_channel_3;
      logic adc2_ref_low;
      logic comparator3_input0;
      logic [`CMP_COUNT-1:0] comparator_shared_reference;
   } analog_conn_type;

   // ************************************************************
   // Peripheral side bundles
   // ************************************************************
   typedef struct packed {
      logic master_mode;
      logic clock_out;
      logic master_data_out;
      logic slave_data_out;
   } spi_core_type;

   typedef struct packed {
      logic clock_in;
      logic master_data_in;
      logic slave_data_in;
      logic slave_select;
      logic receive_enable;
   } spi_pin_type;

   typedef struct packed {
      logic transmit;
      logic drive;
      logic single_wire;
   } sci_core_type;

   typedef struct packed {
      logic out;
      logic drive;
   } timer_core_type;

endpackage : pin_mux_pkg

// >>> hdl/port_b_c_pin_function_mux.sv
// Pin-function multiplexer for port B pins 1-3 and port C pins 6-10
`timescale 1ns/1ps
`include "pin_mux_defines.svh"

// Notes on behaviour
// - After reset every pad is a general-purpose pin with no alternate owner.
// - Each general-purpose pin has its own direction bit.
// - Pin B2 analog acts as converter 2 channel 2 or high reference, and feeds comparator 3 input 3.
// - Pin B3 analog acts as converter 2 channel 3 or low reference, and feeds comparator 3 input 0.
// - Pin B1 analog reaches converter 2 channel 1 and comparator 2 input 0 together.
// - Pin B1 can carry the 12-bit output of the second DAC instead.
// - The slave-out pin is an input as master and drives data as slave.
// - An unselected slave keeps its slave-out driver off.
// - The serial clock pin drives as master and is an input as slave.
// - The master-out pin is an output as master and an input as slave.
// - As slave the port receives only while slave select is asserted.
// - In single-wire mode the async transmit pin carries both directions.
// - Timer A channel 2 reaches its pad both as capture input and output.
// - The comparator reference pad feeds input 5 of all four comparators.
// - Pads connect to numbered crossbar inputs and outputs, pin C8 to 9 and 6.
// - The master-out pin drives data as master and is the data input as slave.
module port_b_c_pin_function_mux #(
   parameter int PIN_COUNT = `PIN_COUNT,
   parameter int DAC_WIDTH = `DAC_WIDTH
) (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic cfg_load,
   input wire pin_mux_pkg::pin_cfg_type cfg_in,
   input wire logic [PIN_COUNT-1:0] pad_in,
   output logic [PIN_COUNT-1:0] pad_out,
   output logic [PIN_COUNT-1:0] pad_oe_n,
   input wire logic [PIN_COUNT-1:0] gpio_out,
   output logic [PIN_COUNT-1:0] gpio_in,
   output pin_mux_pkg::analog_conn_type analog,
   input wire logic [DAC_WIDTH-1:0] dac2_code,
   output logic [DAC_WIDTH-1:0] dac2_level,
   input wire pin_mux_pkg::timer_core_type timer_a_channel_2,
   output logic timer_a_channel_2_capture,
   input wire pin_mux_pkg::spi_core_type sync_serial_port0,
   output pin_mux_pkg::spi_pin_type sync_serial_port0_pins,
   input wire pin_mux_pkg::sci_core_type async_serial_port0,
   output logic async_port0_receive,
   input wire logic [`XBAR_OUT_COUNT-1:0] crossbar_output,
   output logic [`XBAR_IN_COUNT-1:0] crossbar_input
);
   import pin_mux_pkg::*;

   // ************************************************************
   // Configuration register
   // ************************************************************
   pin_cfg_type cfg_ff;
   pin_cfg_type nxt_cfg;
   pin_cfg_type cfg_reset;

   // All pads start as inputs so nothing is driven before software speaks
   assign cfg_reset.func = {PIN_COUNT{func_gpio}};
   assign cfg_reset.gpio_dir = `GPIO_DIR_RESET;
   assign cfg_reset.gpio_out = `GPIO_OUT_RESET;
   assign cfg_reset.pin_2_ref_high = 1'b0;
   assign cfg_reset.pin_3_ref_low = 1'b0;
   assign nxt_cfg = cfg_load ? cfg_in : cfg_ff;

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         cfg_ff <= cfg_reset;
      end else begin
         cfg_ff <= nxt_cfg;
      end
   end

   // ************************************************************
   // Ownership decode
   // ************************************************************
   // Codes that are not legal on a pad fall back to plain GPIO
   wire b1_analog = cfg_ff.func[`PIN_B1] == func_analog;
   wire b1_dac = cfg_ff.func[`PIN_B1] == func_dac;
   wire b2_analog = cfg_ff.func[`PIN_B2] == func_analog;
   wire b3_analog = cfg_ff.func[`PIN_B3] == func_analog;
   wire c6_timer = cfg_ff.func[`PIN_C6] == func_timer;
   wire c6_xin = cfg_ff.func[`PIN_C6] == func_xbar_in;
   wire c6_cref = cfg_ff.func[`PIN_C6] == func_comparator_shared_reference;
   wire c6_ss = cfg_ff.func[`PIN_C6] == func_ss;
   wire c7_ss = cfg_ff.func[`PIN_C7] == func_ss;
   wire c7_txd = cfg_ff.func[`PIN_C7] == func_txd;
   wire c7_xin = cfg_ff.func[`PIN_C7] == func_xbar_in;
   wire c8_miso = cfg_ff.func[`PIN_C8] == func_miso;
   wire c8_rxd = cfg_ff.func[`PIN_C8] == func_rxd;
   wire c8_xin = cfg_ff.func[`PIN_C8] == func_xbar_in;
   wire c8_xout = cfg_ff.func[`PIN_C8] == func_xbar_out;
   wire c9_sclk = cfg_ff.func[`PIN_C9] == func_sclk;
   wire c9_xin = cfg_ff.func[`PIN_C9] == func_xbar_in;
   wire c9_txd = cfg_ff.func[`PIN_C9] == func_txd;
   wire c9_xout = cfg_ff.func[`PIN_C9] == func_xbar_out;
   wire c10_mosi = cfg_ff.func[`PIN_C10] == func_mosi;
   wire c10_xin = cfg_ff.func[`PIN_C10] == func_xbar_in;
   wire c10_miso = cfg_ff.func[`PIN_C10] == func_miso;
   wire c10_xout = cfg_ff.func[`PIN_C10] == func_xbar_out;

   logic [PIN_COUNT-1:0] alt_own;
   logic [PIN_COUNT-1:0] gpio_own;

   assign alt_own[`PIN_B1] = b1_analog | b1_dac;
   assign alt_own[`PIN_B2] = b2_analog;
   assign alt_own[`PIN_B3] = b3_analog;
   assign alt_own[`PIN_C6] = c6_timer | c6_xin | c6_cref | c6_ss;
   assign alt_own[`PIN_C7] = c7_ss | c7_txd | c7_xin;
   assign alt_own[`PIN_C8] = c8_miso | c8_rxd | c8_xin | c8_xout;
   assign alt_own[`PIN_C9] = c9_sclk | c9_xin | c9_txd | c9_xout;
   assign alt_own[`PIN_C10] = c10_mosi | c10_xin | c10_miso | c10_xout;
   assign gpio_own = ~alt_own;

   // ************************************************************
   // Serial port 0 direction control
   // ************************************************************
   wire spi_master = sync_serial_port0.master_mode;
   // Slave select is active low; C6 wins if both pads claim it
   wire ss_level = c6_ss ? pad_in[`PIN_C6] :
                   c7_ss ? pad_in[`PIN_C7] : 1'b1;
   wire slave_selected = ~spi_master & ~ss_level;
   wire miso_drive = ~spi_master & slave_selected;
   wire sclk_drive = spi_master;
   wire mosi_drive = spi_master;
   wire miso_pad_in = c8_miso ? pad_in[`PIN_C8] :
                      c10_miso ? pad_in[`PIN_C10] : 1'b0;

   // ************************************************************
   // Async port 0 line control
   // ************************************************************
   wire sci_single = async_serial_port0.single_wire;
   // In single-wire mode the core turns the driver round itself
   wire txd_drive = ~sci_single | async_serial_port0.drive;
   wire txd_pad_in = c7_txd ? pad_in[`PIN_C7] :
                     c9_txd ? pad_in[`PIN_C9] : 1'b1;
   // Idle line is high when no pad carries the receive signal
   wire rxd_level = sci_single ? txd_pad_in :
                    c8_rxd ? pad_in[`PIN_C8] : 1'b1;

   // ************************************************************
   // Pad output value and driver enable
   // ************************************************************
   logic [PIN_COUNT-1:0] gpio_drv;
   logic [PIN_COUNT-1:0] nxt_pad_out;
   logic [PIN_COUNT-1:0] nxt_drive;

   assign gpio_drv = gpio_own & cfg_ff.gpio_dir;

   // Analog pads only release their digital driver
   assign nxt_pad_out[`PIN_B1] = cfg_ff.gpio_out[`PIN_B1];
   assign nxt_drive[`PIN_B1] = gpio_drv[`PIN_B1];
   assign nxt_pad_out[`PIN_B2] = cfg_ff.gpio_out[`PIN_B2];
   assign nxt_drive[`PIN_B2] = gpio_drv[`PIN_B2];
   assign nxt_pad_out[`PIN_B3] = cfg_ff.gpio_out[`PIN_B3];
   assign nxt_drive[`PIN_B3] = gpio_drv[`PIN_B3];

   assign nxt_pad_out[`PIN_C6] = c6_timer ? timer_a_channel_2.out :
                                 cfg_ff.gpio_out[`PIN_C6];
   assign nxt_drive[`PIN_C6] = c6_timer ? timer_a_channel_2.drive :
                               gpio_drv[`PIN_C6];

   assign nxt_pad_out[`PIN_C7] = c7_txd ? async_serial_port0.transmit :
                                 cfg_ff.gpio_out[`PIN_C7];
   assign nxt_drive[`PIN_C7] = c7_txd ? txd_drive : gpio_drv[`PIN_C7];

   assign nxt_pad_out[`PIN_C8] =
      c8_miso ? sync_serial_port0.slave_data_out :
      c8_xout ? crossbar_output[`XBAR_OUT_6] :
      cfg_ff.gpio_out[`PIN_C8];
   assign nxt_drive[`PIN_C8] = c8_miso ? miso_drive :
                               c8_xout ? 1'b1 : gpio_drv[`PIN_C8];

   assign nxt_pad_out[`PIN_C9] =
      c9_sclk ? sync_serial_port0.clock_out :
      c9_txd ? async_serial_port0.transmit :
      c9_xout ? crossbar_output[`XBAR_OUT_8] :
      cfg_ff.gpio_out[`PIN_C9];
   assign nxt_drive[`PIN_C9] = c9_sclk ? sclk_drive :
                               c9_txd ? txd_drive :
                               c9_xout ? 1'b1 : gpio_drv[`PIN_C9];

   assign nxt_pad_out[`PIN_C10] =
      c10_mosi ? sync_serial_port0.master_data_out :
      c10_miso ? sync_serial_port0.slave_data_out :
      c10_xout ? crossbar_output[`XBAR_OUT_9] :
      cfg_ff.gpio_out[`PIN_C10];
   assign nxt_drive[`PIN_C10] = c10_mosi ? mosi_drive :
                                c10_miso ? miso_drive :
                                c10_xout ? 1'b1 : gpio_drv[`PIN_C10];

   // ************************************************************
   // Routing toward the cores
   // ************************************************************
   logic [PIN_COUNT-1:0] nxt_gpio_in;
   logic [`XBAR_IN_COUNT-1:0] nxt_xbar_in;
   spi_pin_type nxt_spi_pins;
   analog_conn_type nxt_analog;
   logic [DAC_WIDTH-1:0] nxt_dac;
   logic nxt_capture;

   // A pad lent to another function reads back as zero on its GPIO bit
   assign nxt_gpio_in = pad_in & gpio_own;

   assign nxt_xbar_in[`XBAR_IN_3] = c6_xin & pad_in[`PIN_C6];
   assign nxt_xbar_in[`XBAR_IN_8] = c7_xin & pad_in[`PIN_C7];
   assign nxt_xbar_in[`XBAR_IN_9] = c8_xin & pad_in[`PIN_C8];
   assign nxt_xbar_in[`XBAR_IN_4] = c9_xin & pad_in[`PIN_C9];
   assign nxt_xbar_in[`XBAR_IN_5] = c10_xin & pad_in[`PIN_C10];

   // Capture sees the pad only while the timer is not driving it
   assign nxt_capture = c6_timer & ~timer_a_channel_2.drive &
                        pad_in[`PIN_C6];

   // Slave-side inputs are blanked outside the select window
   assign nxt_spi_pins.clock_in = slave_selected & c9_sclk &
                                  pad_in[`PIN_C9];
   assign nxt_spi_pins.master_data_in = slave_selected &
                                        c10_mosi & pad_in[`PIN_C10];
   assign nxt_spi_pins.slave_data_in = spi_master & miso_pad_in;
   assign nxt_spi_pins.slave_select = slave_selected;
   assign nxt_spi_pins.receive_enable = spi_master | slave_selected;

   assign nxt_analog.adc2_channel_1 = b1_analog;
   assign nxt_analog.comparator2_input0 = b1_analog;
   assign nxt_analog.dac2_output = b1_dac;
   assign nxt_analog.adc2_channel_2 = b2_analog &
                                      ~cfg_ff.pin_2_ref_high;
   assign nxt_analog.adc2_ref_high = b2_analog & cfg_ff.pin_2_ref_high;
   assign nxt_analog.comparator3_input3 = b2_analog;
   assign nxt_analog.adc2_channel_3 = b3_analog &
                                      ~cfg_ff.pin_3_ref_low;
   assign nxt_analog.adc2_ref_low = b3_analog & cfg_ff.pin_3_ref_low;
   assign nxt_analog.comparator3_input0 = b3_analog;
   assign nxt_analog.comparator_shared_reference =
      {`CMP_COUNT{c6_cref}};

   // Code held at zero while the DAC does not own the pad
   assign nxt_dac = b1_dac ? dac2_code : `DAC_RESET;

   // ************************************************************
   // Output flip-flops
   // ************************************************************
   // One cycle of latency each way buys glitch-free pad drivers
   logic [PIN_COUNT-1:0] pad_out_ff;
   logic [PIN_COUNT-1:0] pad_oe_n_ff;
   logic [PIN_COUNT-1:0] gpio_in_ff;
   logic [`XBAR_IN_COUNT-1:0] xbar_in_ff;
   spi_pin_type spi_pins_ff;
   analog_conn_type analog_ff;
   logic [DAC_WIDTH-1:0] dac_ff;
   logic capture_ff;
   logic receive_ff;

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         pad_out_ff <= `GPIO_OUT_RESET;
         pad_oe_n_ff <= ~`GPIO_DIR_RESET;
         gpio_in_ff <= '0;
         xbar_in_ff <= '0;
         spi_pins_ff <= '0;
         analog_ff <= '0;
         dac_ff <= `DAC_RESET;
         capture_ff <= 1'b0;
         receive_ff <= 1'b1;
      end else begin
         pad_out_ff <= nxt_pad_out;
         pad_oe_n_ff <= ~nxt_drive;
         gpio_in_ff <= nxt_gpio_in;
         xbar_in_ff <= nxt_xbar_in;
         spi_pins_ff <= nxt_spi_pins;
         analog_ff <= nxt_analog;
         dac_ff <= nxt_dac;
         capture_ff <= nxt_capture;
         receive_ff <= rxd_level;
      end
   end

   assign pad_out = pad_out_ff;
   assign pad_oe_n = pad_oe_n_ff;
   assign gpio_in = gpio_in_ff;
   assign crossbar_input = xbar_in_ff;
   assign sync_serial_port0_pins = spi_pins_ff;
   assign analog = analog_ff;
   assign dac2_level = dac_ff;
   assign timer_a_channel_2_capture = capture_ff;
   assign async_port0_receive = receive_ff;

   // gpio_out input is unused; the pads drive the loaded copy in cfg_ff
   wire unused_gpio_out = ^gpio_out;

endmodule : port_b_c_pin_function_mux

// >>> tb/port_b_c_pin_function_mux_props.sv
// Port-level checks for the pin-function multiplexer
`timescale 1ns/1ps
`include "pin_mux_defines.svh"
module port_b_c_pin_function_mux_props
   import pin_mux_pkg::*;
#(
   parameter int PIN_COUNT = 8,
   parameter int DAC_WIDTH = 12
) (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic cfg_load,
   input wire pin_mux_pkg::pin_cfg_type cfg_in,
   input wire logic [PIN_COUNT-1:0] pad_in,
   input wire logic [PIN_COUNT-1:0] pad_out,
   input wire logic [PIN_COUNT-1:0] pad_oe_n,
   input wire pin_mux_pkg::analog_conn_type analog,
   input wire pin_mux_pkg::spi_core_type sync_serial_port0,
   input wire pin_mux_pkg::spi_pin_type sync_serial_port0_pins,
   input wire logic [`XBAR_OUT_COUNT-1:0] crossbar_output
);
   pin_cfg_type q_ff;
   logic [1:0] run_ff;
   logic [PIN_COUNT-1:0] gown;
   logic ok;
   logic ss_lvl;
   logic sel;

   // Mirror of the loaded selection, so outputs can be tied to their cause
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         q_ff <= '0;
      end else if (cfg_load) begin
         q_ff <= cfg_in;
      end
   end
   // The edge just after release may still show reset values
   always_ff @(posedge mclk) begin
      run_ff <= {run_ff[0], rst_n};
   end
   always_comb begin
      for (int i = 0; i < PIN_COUNT; i++) gown[i] = q_ff.func[i] == func_gpio;
   end
   assign ok = &run_ff;
   assign ss_lvl = q_ff.func[3] == func_ss ? pad_in[3] :
      (q_ff.func[4] == func_ss ? pad_in[4] : 1'b1);
   assign sel = !sync_serial_port0.master_mode && !ss_lvl;

   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);

   sequence s_release;
      $rose(rst_n) && !cfg_load;
   endsequence
   sequence s_load_xbar;
      rst_n && cfg_load && cfg_in.func[5] == func_xbar_out ##1 !cfg_load;
   endsequence

   property p_idle;
      s_release |=> pad_oe_n == 8'hff && analog == '0;
   endproperty
   a_idle: assert property (p_idle)
      else $error("pads not idle after reset");
   property p_gpio_dir;
      ok |-> ((pad_oe_n ^ ~$past(q_ff.gpio_dir)) & $past(gown)) == '0;
   endproperty
   a_gpio_dir: assert property (p_gpio_dir)
      else $error("gpio driver enable does not follow direction");
   property p_b2;
      ok && $past(q_ff.func[1]) == func_analog |->
         analog.adc2_ref_high == $past(q_ff.pin_2_ref_high) &&
         analog.adc2_channel_2 != analog.adc2_ref_high &&
         analog.comparator3_input3;
   endproperty
   a_b2: assert property (p_b2)
      else $error("pad b2 analog routing wrong");
   property p_b1;
      ok && $past(q_ff.func[0]) == func_analog |-> pad_oe_n[0] &&
         analog.adc2_channel_1 && analog.comparator2_input0;
   endproperty
   a_b1: assert property (p_b1)
      else $error("pad b1 analog not on both inputs");
   property p_miso;
      ok && $past(q_ff.func[5]) == func_miso |-> pad_oe_n[5] == !$past(sel);
   endproperty
   a_miso: assert property (p_miso)
      else $error("slave data out driver wrong");
   property p_sclk;
      ok && $past(q_ff.func[6]) == func_sclk |->
         pad_oe_n[6] == !$past(sync_serial_port0.master_mode);
   endproperty
   a_sclk: assert property (p_sclk)
      else $error("serial clock direction wrong");
   property p_recv;
      ok |-> sync_serial_port0_pins.slave_select == $past(sel) &&
         sync_serial_port0_pins.receive_enable ==
         ($past(sync_serial_port0.master_mode) || $past(sel));
   endproperty
   a_recv: assert property (p_recv)
      else $error("receive enable does not follow select");
   property p_xbar;
      s_load_xbar |=> !pad_oe_n[5] && pad_out[5] == $past(crossbar_output[0]);
   endproperty
   a_xbar: assert property (p_xbar)
      else $error("crossbar output not on pad c8");
endmodule : port_b_c_pin_function_mux_props

bind port_b_c_pin_function_mux port_b_c_pin_function_mux_props #(
   .PIN_COUNT(PIN_COUNT), .DAC_WIDTH(DAC_WIDTH)
) i_props (
   .mclk(mclk), .rst_n(rst_n), .cfg_load(cfg_load), .cfg_in(cfg_in),
   .pad_in(pad_in), .pad_out(pad_out), .pad_oe_n(pad_oe_n), .analog(analog),
   .sync_serial_port0(sync_serial_port0),
   .sync_serial_port0_pins(sync_serial_port0_pins),
   .crossbar_output(crossbar_output)
);

// >>> tb/pad_peer.sv
// Far side of the pads: external drivers and undriven wires
`timescale 1ns/1ps
module pad_peer #(
   parameter int N = 8
) (
   input wire logic mclk,
   input wire logic [N-1:0] pad_out,
   input wire logic [N-1:0] pad_oe_n,
   input wire logic [N-1:0] ext_en,
   input wire logic [N-1:0] ext_val,
   output logic [N-1:0] pad_in
);
   logic [N-1:0] last_ff = '0;

   // A floating pad toggles, so a stale level never passes for a real one
   always_ff @(posedge mclk) begin
      last_ff <= ~last_ff;
   end
   assign pad_in = (~pad_oe_n & pad_out) | (pad_oe_n & ext_en & ext_val)
      | (pad_oe_n & ~ext_en & ~last_ff);
endmodule : pad_peer

// >>> tb/port_b_c_pin_function_mux_tb.sv
// Self-checking bench for the port B / port C pin-function multiplexer
`timescale 1ns/1ps
module port_b_c_pin_function_mux_tb;
   import pin_mux_pkg::*;
   logic mclk = 0;
   logic rst_n = 0;
   logic cfg_load = 0;
   pin_cfg_type cfg_in = '0;
   logic [7:0] pad_in, pad_out, pad_oe_n, gpio_in, e_oe, e_po, e_gi;
   logic [7:0] ext_en = 0, ext_val = 0, gpio_out = 0;
   analog_conn_type analog, e_an;
   logic [11:0] dac2_code = 0, dac2_level, e_dl;
   timer_core_type tim = '0;
   spi_core_type spi = '0;
   spi_pin_type spi_pins, e_sp;
   sci_core_type sci = '0;
   logic [2:0] xo = 0;
   logic [4:0] xi, e_xi;
   logic cap, rx, e_rx, e_cap, ss, sel;
   logic [1:0] run = 0;
   int errors = 0;
   int checks_done = 0;
   logic [31:0] seed = 84;
   pin_cfg_type m;
   int xin[8] = '{0, 0, 0, 0, 3, 4, 1, 2};
   logic [31:0] ftab[7] = '{32'h00000000, 32'hcb873111, 32'h87965112,
      32'haaa46000, 32'h44404000, 32'hcb860000, 32'hecb87f23};
   logic [1:0] rtab[7] = '{2'b00, 2'b10, 2'b01, 2'b11, 2'b00, 2'b00, 2'b11};
   // Function codes each pad offers, one bit per code
   logic [15:0] legal[8] = '{16'h0007, 16'h0003, 16'h0003, 16'h0079,
      16'h00d1, 16'h0711, 16'h0c91, 16'h1511};
   pin_func_type pf;

   always #5 mclk = ~mclk;

   port_b_c_pin_function_mux i_dut (
      .mclk(mclk), .rst_n(rst_n), .cfg_load(cfg_load), .cfg_in(cfg_in),
      .pad_in(pad_in), .pad_out(pad_out), .pad_oe_n(pad_oe_n),
      .gpio_out(gpio_out), .gpio_in(gpio_in), .analog(analog),
      .dac2_code(dac2_code), .dac2_level(dac2_level),
      .timer_a_channel_2(tim), .timer_a_channel_2_capture(cap),
      .sync_serial_port0(spi), .sync_serial_port0_pins(spi_pins),
      .async_serial_port0(sci), .async_port0_receive(rx),
      .crossbar_output(xo), .crossbar_input(xi)
   );
   pad_peer i_peer (
      .mclk(mclk), .pad_out(pad_out), .pad_oe_n(pad_oe_n),
      .ext_en(ext_en), .ext_val(ext_val), .pad_in(pad_in)
   );

   // ****************************************
   // Reference model, one cycle behind the inputs
   // ****************************************
   always @(posedge mclk) begin
      e_oe = 8'hff;
      e_po = 8'h00;
      e_gi = 8'h00;
      e_an = '0;
      e_dl = 12'h000;
      e_xi = 5'h00;
      e_cap = 1'b0;
      e_rx = 1'b1;
      e_sp = '0;
      ss = m.func[3] == func_ss ? pad_in[3] :
         (m.func[4] == func_ss ? pad_in[4] : 1'b1);
      sel = !spi.master_mode && !ss;
      e_sp.slave_select = sel;
      e_sp.receive_enable = spi.master_mode || sel;
      // Walk downwards so the lower pad wins a shared input
      for (int i = 7; i >= 0; i--) begin
         // Codes a pad does not offer behave as plain GPIO
         pf = legal[i][m.func[i]] ? m.func[i] : func_gpio;
         case (pf)
            func_gpio: begin
               e_oe[i] = !m.gpio_dir[i];
               e_po[i] = m.gpio_out[i];
               e_gi[i] = pad_in[i];
            end
            func_timer: begin
               e_oe[i] = !tim.drive;
               e_po[i] = tim.out;
               e_cap = !tim.drive && pad_in[i];
            end
            func_xbar_in: e_xi[xin[i]] = pad_in[i];
            func_comparator_shared_reference: e_an.comparator_shared_reference = 4'hf;
            func_txd: begin
               e_oe[i] = sci.single_wire && !sci.drive;
               e_po[i] = sci.transmit;
               if (sci.single_wire) e_rx = pad_in[i];
            end
            func_miso: begin
               e_oe[i] = !sel;
               e_po[i] = spi.slave_data_out;
               if (spi.master_mode) e_sp.slave_data_in = pad_in[i];
            end
            func_rxd: if (!sci.single_wire) e_rx = pad_in[i];
            func_xbar_out: begin
               e_oe[i] = 1'b0;
               e_po[i] = xo[i - 5];
            end
            func_sclk: begin
               e_oe[i] = !spi.master_mode;
               e_po[i] = spi.clock_out;
               e_sp.clock_in = sel && pad_in[i];
            end
            func_mosi: begin
               e_oe[i] = !spi.master_mode;
               e_po[i] = spi.master_data_out;
               e_sp.master_data_in = sel && pad_in[i];
            end
            default: ;
         endcase
      end
      e_an.adc2_channel_1 = m.func[0] == func_analog;
      e_an.comparator2_input0 = m.func[0] == func_analog;
      e_an.dac2_output = m.func[0] == func_dac;
      if (m.func[0] == func_dac) e_dl = dac2_code;
      if (m.func[1] == func_analog) begin
         e_an.adc2_ref_high = m.pin_2_ref_high;
         e_an.adc2_channel_2 = !m.pin_2_ref_high;
         e_an.comparator3_input3 = 1'b1;
      end
      if (m.func[2] == func_analog) begin
         e_an.adc2_ref_low = m.pin_3_ref_low;
         e_an.adc2_channel_3 = !m.pin_3_ref_low;
         e_an.comparator3_input0 = 1'b1;
      end
      if (!rst_n) m = '0;
      else if (cfg_load) m = cfg_in;
      run <= {run[0], rst_n};
   end

   always @(negedge mclk) begin
      if (run == 2'b11) begin
         check("pad_oe_n", pad_oe_n, e_oe);
         check("pad_out", pad_out & ~e_oe, e_po & ~e_oe);
         check("gpio_in", gpio_in, e_gi);
         check("analog", analog, e_an);
         check("dac2_level", dac2_level, e_dl);
         check("spi_pins", spi_pins, e_sp);
         check("receive", rx, e_rx);
         check("capture", cap, e_cap);
         check("crossbar_input", xi, e_xi);
      end
   end

   // ****************************************
   // Stimulus and reporting
   // ****************************************
   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction : xs

   task automatic check(input string name, input logic [31:0] seen,
      input logic [31:0] exp);
      checks_done++;
      if (seen !== exp || $isunknown(seen)) begin
         errors++;
         $display("ERROR %s expected %h seen %h", name, exp, seen);
      end
   endtask : check

   task automatic step();
      @(posedge mclk);
      #1;
      cfg_load = 1'b0;
      {ext_en, ext_val, gpio_out, xo} = 27'(xs());
      {dac2_code, tim, spi, sci} = 21'(xs());
   endtask : step

   task automatic load(input logic [31:0] f, input logic [1:0] r);
      logic [31:0] v;
      v = xs();
      @(posedge mclk);
      #1;
      cfg_load = 1'b1;
      cfg_in = pin_cfg_type'({f, v[15:0], r});
   endtask : load

   task automatic final_report();
      $display("checks %0d errors %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : final_report

   initial begin
      repeat (20) @(posedge mclk);
      #1;
      rst_n = 1'b1;
      // Loads 0 and 1 go back to back
      for (int k = 0; k < 7; k++) begin
         load(ftab[k], rtab[k]);
         if (k != 0) repeat (300) step();
         $display("test %0d done", k);
      end
      rst_n = 1'b0;
      repeat (3) step();
      rst_n = 1'b1;
      repeat (50) step();
      $display("test reset done");
      final_report();
   end

   initial begin
      repeat (20000) @(posedge mclk);
      errors++;
      final_report();
   end
endmodule : port_b_c_pin_function_mux_tb
